// ### design/mrrse_pkg.sv
/*
 * shared constants, op codes and decode helpers for the rotate/return/skip
 * execution block. assumes the core's decoder presents one op per cycle.
 */
`default_nettype none
package mrrse_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 11;
    localparam int REG_AW = 2;
    localparam int FLAG_W = 4;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [1:0] REG_ACC = 2'h0;
    localparam logic [1:0] REG_FLAGS = 2'h1;
    localparam logic [1:0] REG_CTRL = 2'h2;
    // ----------------------------------------
    // flag positions and values
    // ----------------------------------------
    localparam int FLG_C = 0;
    localparam int FLG_HC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int MSB = 7;
    localparam int NIB = 4;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic GATE_RST = 1'b0;
    localparam logic [10:0] PC_RST = 11'h000;
    typedef enum logic [4:0] {
        OP_NONE, OP_CALL_EXIT, OP_CALL_EXIT_LIT, OP_INTERRUPT_EXIT,
        OP_ROTATE_LEFT, OP_ROTATE_LEFT_COPY,
        OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_LEFT_THRU_CARRY_COPY,
        OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_COPY,
        OP_ROTATE_RIGHT_THRU_CARRY, OP_ROTATE_RIGHT_THRU_CARRY_COPY,
        OP_SUBTRACT_TO_MEMORY, OP_SET_BYTE, OP_SET_BIT,
        OP_INCREMENT_SKIP_ZERO, OP_INCREMENT_COPY_SKIP_ZERO,
        OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_COPY_SKIP_ZERO,
        OP_SKIP_BIT_NONZERO
    } mrrse_op_e;
    typedef enum logic {ST_RUN, ST_DUMMY} mrrse_state_e;
    // copy forms land in the working register instead of memory
    function automatic logic mrrse_is_copy(input mrrse_op_e op);
        case (op)
            OP_ROTATE_LEFT_COPY, OP_ROTATE_LEFT_THRU_CARRY_COPY,
            OP_ROTATE_RIGHT_COPY, OP_ROTATE_RIGHT_THRU_CARRY_COPY,
            OP_INCREMENT_COPY_SKIP_ZERO, OP_DECREMENT_COPY_SKIP_ZERO: mrrse_is_copy = 1'b1;
            default: mrrse_is_copy = 1'b0;
        endcase
    endfunction
endpackage
`default_nettype wire

// ### design/mrrse_alu_if.sv
/*
 * carrier between the execution top and its combinational datapath.
 * assumes both ends sit in the clk_sys domain.
 */
`default_nettype none
interface mrrse_alu_if;
    mrrse_pkg::mrrse_op_e op;
    logic [7:0] acc;
    logic [7:0] m;
    logic [7:0] imm;
    logic [2:0] bsel;
    logic cin;
    logic [7:0] res;
    logic cout;
    logic hc;
    logic ov;
    logic zf;
    logic wr_mem;
    logic wr_acc;
    logic c_we;
    logic arith_we;
    logic skip_req;
    logic pop;
    logic gate_set;
    modport core (output op, acc, m, imm, bsel, cin,
        input res, cout, hc, ov, zf, wr_mem, wr_acc, c_we, arith_we, skip_req, pop, gate_set);
    modport alu (input op, acc, m, imm, bsel, cin,
        output res, cout, hc, ov, zf, wr_mem, wr_acc, c_we, arith_we, skip_req, pop, gate_set);
endinterface
`default_nettype wire

// ### design/mrrse_alu.sv
/*
 * combinational datapath: rotates, subtract, set, inc/dec and skip decisions.
 * assumes operands are stable for the cycle the op is presented.
 */
`default_nettype none
module mrrse_alu (
    mrrse_alu_if.alu a
);
    logic [8:0] diff;
    logic [4:0] hsum;
    logic [7:0] incv;
    logic [7:0] decv;
    logic cp;
    always_comb begin
        cp = mrrse_pkg::mrrse_is_copy(a.op);
        // subtract as a + ~b + 1 so carry reads as no borrow
        diff = {1'b0, a.acc} + {1'b0, ~a.m} + 9'h001; // RULE16
        hsum = {1'b0, a.acc[3:0]} + {1'b0, ~a.m[3:0]} + 5'h01; // RULE16
        incv = a.m + mrrse_pkg::BYTE_ONE;
        decv = 8'(({1'b0, a.m} + {1'b0, ~mrrse_pkg::BYTE_ONE}) + 9'h001); // RULE16
        a.res = a.m;
        a.cout = a.cin;
        a.hc = hsum[mrrse_pkg::NIB];
        a.ov = (a.acc[mrrse_pkg::MSB] ^ a.m[mrrse_pkg::MSB]) & (a.acc[mrrse_pkg::MSB] ^ diff[mrrse_pkg::MSB]);
        a.zf = 1'b0;
        a.wr_mem = 1'b0;
        a.wr_acc = 1'b0;
        a.c_we = 1'b0;
        a.arith_we = 1'b0;
        a.skip_req = 1'b0;
        a.pop = 1'b0;
        a.gate_set = 1'b0;
        case (a.op)
            mrrse_pkg::OP_CALL_EXIT: begin
                a.pop = 1'b1; // RULE1
            end
            mrrse_pkg::OP_CALL_EXIT_LIT: begin
                a.pop = 1'b1; // RULE2
                a.res = a.imm; // RULE2
                a.wr_acc = 1'b1; // RULE2
            end
            mrrse_pkg::OP_INTERRUPT_EXIT: begin
                a.pop = 1'b1; // RULE3
                a.gate_set = 1'b1; // RULE3
            end
            mrrse_pkg::OP_ROTATE_LEFT, mrrse_pkg::OP_ROTATE_LEFT_COPY: begin
                a.res = {a.m[6:0], a.m[mrrse_pkg::MSB]}; // RULE4 RULE5
                a.wr_mem = !cp; // RULE4
                a.wr_acc = cp; // RULE5
            end
            mrrse_pkg::OP_ROTATE_LEFT_THRU_CARRY, mrrse_pkg::OP_ROTATE_LEFT_THRU_CARRY_COPY: begin
                a.res = {a.m[6:0], a.cin}; // RULE6 RULE7
                a.cout = a.m[mrrse_pkg::MSB]; // RULE6 RULE7
                a.c_we = 1'b1;
                a.wr_mem = !cp; // RULE6
                a.wr_acc = cp; // RULE7
            end
            mrrse_pkg::OP_ROTATE_RIGHT, mrrse_pkg::OP_ROTATE_RIGHT_COPY: begin
                a.res = {a.m[0], a.m[7:1]}; // RULE8 RULE9
                a.wr_mem = !cp; // RULE8
                a.wr_acc = cp; // RULE9
            end
            mrrse_pkg::OP_ROTATE_RIGHT_THRU_CARRY, mrrse_pkg::OP_ROTATE_RIGHT_THRU_CARRY_COPY: begin
                a.res = {a.cin, a.m[7:1]}; // RULE10
                a.cout = a.m[0]; // RULE10
                a.c_we = 1'b1;
                a.wr_mem = !cp; // RULE10
                a.wr_acc = cp; // RULE10
            end
            mrrse_pkg::OP_SUBTRACT_TO_MEMORY: begin
                a.res = diff[7:0]; // RULE11
                a.cout = diff[8]; // RULE11
                a.zf = (diff[7:0] == mrrse_pkg::BYTE_ZERO); // RULE11
                a.arith_we = 1'b1; // RULE11
                a.wr_mem = 1'b1; // RULE11
            end
            mrrse_pkg::OP_SET_BYTE: begin
                a.res = mrrse_pkg::ALL_ONES; // RULE12
                a.wr_mem = 1'b1;
            end
            mrrse_pkg::OP_SET_BIT: begin
                a.res = a.m | (mrrse_pkg::BYTE_ONE << a.bsel); // RULE12
                a.wr_mem = 1'b1;
            end
            mrrse_pkg::OP_INCREMENT_SKIP_ZERO, mrrse_pkg::OP_INCREMENT_COPY_SKIP_ZERO: begin
                a.res = incv; // RULE13
                a.skip_req = (incv == mrrse_pkg::BYTE_ZERO); // RULE13
                a.wr_mem = !cp; // RULE13
                a.wr_acc = cp; // RULE13
            end
            mrrse_pkg::OP_DECREMENT_SKIP_ZERO, mrrse_pkg::OP_DECREMENT_COPY_SKIP_ZERO: begin
                a.res = decv; // RULE13
                a.skip_req = (decv == mrrse_pkg::BYTE_ZERO); // RULE13
                a.wr_mem = !cp; // RULE13
                a.wr_acc = cp; // RULE13
            end
            mrrse_pkg::OP_SKIP_BIT_NONZERO: begin
                a.skip_req = a.m[a.bsel]; // RULE15
            end
            default: begin
                a.res = a.m;
            end
        endcase
    end
endmodule // mrrse_alu
`default_nettype wire

// ### design/mrrse_skip.sv
/*
 * skip sequencer: turns a taken skip into one discarded-fetch dummy cycle.
 * assumes the caller only raises take while accept is high.
 */
`default_nettype none
module mrrse_skip (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic take,
    input wire logic skip_req,
    output logic accept,
    output logic dummy_q
);
    mrrse_pkg::mrrse_state_e st_q;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_q <= mrrse_pkg::ST_RUN;
        end else if (ce) begin
            case (st_q)
                mrrse_pkg::ST_RUN: begin
                    if (take && skip_req) begin
                        st_q <= mrrse_pkg::ST_DUMMY; // RULE14
                    end
                end
                mrrse_pkg::ST_DUMMY: begin
                    st_q <= mrrse_pkg::ST_RUN; // RULE14
                end
                default: begin
                    st_q <= mrrse_pkg::ST_RUN;
                end
            endcase
        end
    end
    // the fetched word during the dummy cycle is dropped, not executed
    assign accept = (st_q == mrrse_pkg::ST_RUN); // RULE14
    assign dummy_q = (st_q == mrrse_pkg::ST_DUMMY);
endmodule // mrrse_skip
`default_nettype wire

// ### design/mrrse_exec.sv
/*
 * execution top for returns, rotates, subtract-to-memory, set and skip ops.
 * holds the working register, flags and interrupt gate; offers a small
 * register port. assumes the core holds the memory address for the cycle
 * after an op so the registered write lands on the same byte.
 */
// The register offsets and the address-and-strobe port were left to the implementer.
`default_nettype none
// Function
// RULE1 - plain return pops stack into pc, flags untouched
// RULE2 - literal return pops pc and loads immediate byte into working register
// RULE3 - interrupt return pops pc and sets global interrupt gate
// RULE4 - rotate left writes rotated byte back, no flag change
// RULE5 - copy rotate left puts rotated byte in working register only
// RULE6 - rotate left through carry: bit 7 to carry, carry to bit 0
// RULE7 - copy form of left-through-carry updates carry, writes working register
// RULE8 - rotate right writes rotated byte back, no flag change
// RULE9 - copy rotate right puts rotated byte in working register only
// RULE10 - rotate right through carry: bit 0 to carry, carry to bit 7
// RULE11 - subtract memory from working register into memory, update four flags
// RULE12 - set byte writes all ones; set bit forces one bit; no flags
// RULE13 - increment/decrement, skip on zero result; copy forms write register
// RULE14 - taken skip discards next fetch with one dummy cycle
// RULE15 - bit test skips when selected bit is nonzero
// RULE16 - subtraction is a plus ones-complement plus one; carry means no borrow
module mrrse_exec (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic exec_valid,
    input wire logic [4:0] exec_op,
    input wire logic [7:0] exec_imm,
    input wire logic [2:0] exec_bit,
    input wire logic [7:0] mem_rdata,
    input wire logic [10:0] stack_top,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_q,
    output logic pc_load_q,
    output logic [10:0] pc_value_q,
    output logic stack_pop_q,
    output logic mem_we_q,
    output logic [7:0] mem_wdata_q,
    output logic [7:0] acc_q,
    output logic [3:0] flags_q,
    output logic global_irq_gate_q,
    output logic skip_dummy_q
);

    // ----------------------------------------
    // datapath hookup
    // ----------------------------------------
    mrrse_alu_if alu_bus ();
    logic accept;
    logic take;
    logic dummy;

    assign alu_bus.op = mrrse_pkg::mrrse_op_e'(exec_op);
    assign alu_bus.acc = acc_q;
    assign alu_bus.m = mem_rdata;
    assign alu_bus.imm = exec_imm;
    assign alu_bus.bsel = exec_bit;
    assign alu_bus.cin = flags_q[mrrse_pkg::FLG_C];

    mrrse_alu u_alu (
        .a(alu_bus)
    );

    // ops arriving in the dummy cycle are the discarded fetch
    assign take = exec_valid && accept; // RULE14

    mrrse_skip u_skip (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .take(take),
        .skip_req(alu_bus.skip_req),
        .accept(accept),
        .dummy_q(dummy)
    );

    assign skip_dummy_q = dummy;

    // ----------------------------------------
    // software write decode
    // ----------------------------------------
    logic sw_acc;
    logic sw_flags;
    logic sw_ctrl;

    assign sw_acc = reg_wr && (reg_addr == mrrse_pkg::REG_ACC);
    assign sw_flags = reg_wr && (reg_addr == mrrse_pkg::REG_FLAGS);
    assign sw_ctrl = reg_wr && (reg_addr == mrrse_pkg::REG_CTRL);

    // ----------------------------------------
    // program counter and stack pop
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pc_load_q <= 1'b0;
            stack_pop_q <= 1'b0;
            pc_value_q <= mrrse_pkg::PC_RST;
        end else if (ce) begin
            pc_load_q <= take && alu_bus.pop; // RULE1 RULE2 RULE3
            stack_pop_q <= take && alu_bus.pop; // RULE1 RULE2 RULE3
            if (take && alu_bus.pop) begin
                pc_value_q <= stack_top; // RULE1 RULE2 RULE3
            end
        end
    end

    // ----------------------------------------
    // memory write port
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mem_we_q <= 1'b0;
            mem_wdata_q <= mrrse_pkg::BYTE_ZERO;
        end else if (ce) begin
            // copy forms never raise the strobe, so memory stays intact
            mem_we_q <= take && alu_bus.wr_mem; // RULE4 RULE6 RULE8 RULE11 RULE12 RULE13
            if (take && alu_bus.wr_mem) begin
                mem_wdata_q <= alu_bus.res;
            end
        end
    end

    // ----------------------------------------
    // working register
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            acc_q <= mrrse_pkg::ACC_RST;
        end else if (ce) begin
            // execution beats a same-cycle software write
            if (take && alu_bus.wr_acc) begin
                acc_q <= alu_bus.res; // RULE2 RULE5 RULE7 RULE9 RULE10 RULE13
            end else if (sw_acc) begin
                acc_q <= reg_wdata;
            end
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            flags_q <= mrrse_pkg::FLAGS_RST;
        end else if (ce) begin
            if (take && alu_bus.arith_we) begin
                flags_q[mrrse_pkg::FLG_C] <= alu_bus.cout; // RULE11 RULE16
                flags_q[mrrse_pkg::FLG_HC] <= alu_bus.hc; // RULE11
                flags_q[mrrse_pkg::FLG_Z] <= alu_bus.zf; // RULE11
                flags_q[mrrse_pkg::FLG_OV] <= alu_bus.ov; // RULE11
            end else if (take && alu_bus.c_we) begin
                // rotates through carry touch the carry bit alone
                flags_q[mrrse_pkg::FLG_C] <= alu_bus.cout; // RULE6 RULE7 RULE10
                if (sw_flags) begin
                    flags_q[mrrse_pkg::FLG_HC] <= reg_wdata[mrrse_pkg::FLG_HC];
                    flags_q[mrrse_pkg::FLG_Z] <= reg_wdata[mrrse_pkg::FLG_Z];
                    flags_q[mrrse_pkg::FLG_OV] <= reg_wdata[mrrse_pkg::FLG_OV];
                end
            end else if (sw_flags) begin
                flags_q <= reg_wdata[mrrse_pkg::FLAG_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // global interrupt gate
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            global_irq_gate_q <= mrrse_pkg::GATE_RST;
        end else if (ce) begin
            // set wins so a clear racing the interrupt exit cannot mask it
            if (take && alu_bus.gate_set) begin
                global_irq_gate_q <= 1'b1; // RULE3
            end else if (sw_ctrl) begin
                global_irq_gate_q <= reg_wdata[0];
            end
        end
    end

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        case (reg_addr)
            mrrse_pkg::REG_ACC: begin
                rd_mux = acc_q;
            end
            mrrse_pkg::REG_FLAGS: begin
                rd_mux = {{(mrrse_pkg::DATA_W - mrrse_pkg::FLAG_W){1'b0}}, flags_q};
            end
            mrrse_pkg::REG_CTRL: begin
                rd_mux = {6'h00, dummy, global_irq_gate_q};
            end
            default: begin
                rd_mux = mrrse_pkg::BYTE_ZERO;
            end
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            reg_rdata_q <= mrrse_pkg::BYTE_ZERO;
        end else if (ce) begin
            if (reg_rd) begin
                reg_rdata_q <= rd_mux;
            end else begin
                reg_rdata_q <= mrrse_pkg::BYTE_ZERO;
            end
        end
    end

endmodule // mrrse_exec
`default_nettype wire

// ### sim/mrrse_exec_chk.sv
/*
 * concurrent checks on the execution top, watching its ports only.
 * assumes no sw flag write lands beside an op.
 */
`default_nettype none
module mrrse_exec_chk (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic exec_valid,
    input wire logic [4:0] exec_op,
    input wire logic [7:0] exec_imm,
    input wire logic [2:0] exec_bit,
    input wire logic [7:0] mem_rdata,
    input wire logic [10:0] stack_top,
    input wire logic pc_load_q,
    input wire logic [10:0] pc_value_q,
    input wire logic stack_pop_q,
    input wire logic mem_we_q,
    input wire logic [7:0] mem_wdata_q,
    input wire logic [7:0] acc_q,
    input wire logic [3:0] flags_q,
    input wire logic global_irq_gate_q,
    input wire logic skip_dummy_q
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // dummy-cycle ops are the dropped fetch
    logic take;
    assign take = rstn && ce && exec_valid && !skip_dummy_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_ret;
        take && exec_op == mrrse_pkg::OP_CALL_EXIT |=>
            pc_load_q && stack_pop_q && pc_value_q == $past(stack_top) && flags_q == $past(flags_q);
    endproperty
    a_ret: assert property (p_ret) else $error("return off");
    property p_ret_lit;
        take && exec_op == mrrse_pkg::OP_CALL_EXIT_LIT |=> pc_load_q && acc_q == $past(exec_imm);
    endproperty
    a_ret_lit: assert property (p_ret_lit) else $error("literal return off");
    property p_interrupt_exit;
        take && exec_op == mrrse_pkg::OP_INTERRUPT_EXIT |=> stack_pop_q && global_irq_gate_q;
    endproperty
    a_interrupt_exit: assert property (p_interrupt_exit) else $error("gate not set");
    property p_rl;
        take && exec_op == mrrse_pkg::OP_ROTATE_LEFT |=> mem_we_q &&
            mem_wdata_q == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && $stable(flags_q);
    endproperty
    a_rl: assert property (p_rl) else $error("left rotate off");
    property p_rlc_copy;
        take && exec_op == mrrse_pkg::OP_ROTATE_LEFT_THRU_CARRY_COPY |=> !mem_we_q &&
            acc_q == {$past(mem_rdata[6:0]), $past(flags_q[0])} && flags_q[0] == $past(mem_rdata[7]);
    endproperty
    a_rlc_copy: assert property (p_rlc_copy) else $error("left carry copy off");
    property p_rrc;
        take && exec_op == mrrse_pkg::OP_ROTATE_RIGHT_THRU_CARRY |=> mem_we_q &&
            mem_wdata_q == {$past(flags_q[0]), $past(mem_rdata[7:1])} && flags_q[0] == $past(mem_rdata[0]);
    endproperty
    a_rrc: assert property (p_rrc) else $error("right carry rotate off");
    property p_sub;
        take && exec_op == mrrse_pkg::OP_SUBTRACT_TO_MEMORY |=> mem_we_q &&
            mem_wdata_q == $past(acc_q) - $past(mem_rdata) && flags_q[0] == ($past(acc_q) >= $past(mem_rdata));
    endproperty
    a_sub: assert property (p_sub) else $error("subtract off");
    property p_set_byte;
        take && exec_op == mrrse_pkg::OP_SET_BYTE |=> mem_we_q && mem_wdata_q == 8'hff && $stable(flags_q);
    endproperty
    a_set_byte: assert property (p_set_byte) else $error("set byte off");
    property p_siz;
        take && exec_op == mrrse_pkg::OP_INCREMENT_SKIP_ZERO |=>
            skip_dummy_q == ($past(mem_rdata) == 8'hff) && mem_wdata_q == $past(mem_rdata) + 8'h01;
    endproperty
    a_siz: assert property (p_siz) else $error("increment skip off");
    property p_dummy_one;
        skip_dummy_q && ce |=> !skip_dummy_q;
    endproperty
    a_dummy_one: assert property (p_dummy_one) else $error("dummy cycle too long");
    property p_snz;
        take && exec_op == mrrse_pkg::OP_SKIP_BIT_NONZERO |=>
            skip_dummy_q == $past(mem_rdata[exec_bit]) && !mem_we_q;
    endproperty
    a_snz: assert property (p_snz) else $error("bit test skip off");
    c_skip: cover property (take && exec_op == mrrse_pkg::OP_INCREMENT_SKIP_ZERO ##1 skip_dummy_q);
    c_refused: cover property (skip_dummy_q && exec_valid);
    c_interrupt_exit: cover property (take && exec_op == mrrse_pkg::OP_INTERRUPT_EXIT);
endmodule // mrrse_exec_chk
bind mrrse_exec mrrse_exec_chk mrrse_exec_chk_inst (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .exec_valid(exec_valid), .exec_op(exec_op),
    .exec_imm(exec_imm), .exec_bit(exec_bit), .mem_rdata(mem_rdata), .stack_top(stack_top),
    .pc_load_q(pc_load_q), .pc_value_q(pc_value_q),
    .stack_pop_q(stack_pop_q), .mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q), .acc_q(acc_q),
    .flags_q(flags_q), .global_irq_gate_q(global_irq_gate_q), .skip_dummy_q(skip_dummy_q)
);
`default_nettype wire

// ### sim/mrrse_rotate_return_skip_exec_test.sv
/*
 * self-checking bench for the execution top: op and register tasks.
 * assumes the design package is compiled first; ce stays high.
 */
`default_nettype none
module mrrse_rotate_return_skip_exec_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rstn, ce, exec_valid, reg_wr, reg_rd;
    logic [4:0] exec_op;
    logic [7:0] exec_imm, mem_rdata, reg_wdata, reg_rdata_q, mem_wdata_q, acc_q, a, m, r, rd;
    logic [2:0] exec_bit;
    logic [10:0] stack_top, pc_value_q;
    logic [1:0] reg_addr;
    logic [3:0] flags_q, f;
    logic pc_load_q, stack_pop_q, mem_we_q, global_irq_gate_q, skip_dummy_q, c, co;
    int error_cnt = 0;
    int samples_checked = 0;
    mrrse_exec mrrse_exec_inst (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .exec_valid(exec_valid),
        .exec_op(exec_op), .exec_imm(exec_imm), .exec_bit(exec_bit), .mem_rdata(mem_rdata),
        .stack_top(stack_top), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .pc_load_q(pc_load_q), .pc_value_q(pc_value_q),
        .stack_pop_q(stack_pop_q), .mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q), .acc_q(acc_q),
        .flags_q(flags_q), .global_irq_gate_q(global_irq_gate_q), .skip_dummy_q(skip_dummy_q));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // results read 1ns after the take edge
    task automatic do_op(input logic [4:0] op, input logic [7:0] md, imm, input logic [2:0] b);
        @(posedge clk_sys);
        exec_valid <= 1'b1;
        exec_op <= op;
        mem_rdata <= md;
        exec_imm <= imm;
        exec_bit <= b;
        @(posedge clk_sys);
        exec_valid <= 1'b0;
        mem_rdata <= ~md;
        #1;
    endtask
    task automatic reg_write(input logic [1:0] ad, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [1:0] ad, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        {rstn, exec_valid, reg_wr, reg_rd, exec_op, exec_imm, exec_bit, mem_rdata, stack_top, reg_addr, reg_wdata} = '0;
        ce = 1'b1;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            reg_read(i[1:0], rd);
            chk(rd, 16'h0000);
        end
        reg_write(2'h3, 8'h77);
        reg_read(2'h3, rd);
        chk(rd, 16'h0000);
        reg_write(mrrse_pkg::REG_FLAGS, 8'h05);
        stack_top <= 11'h5a3;
        do_op(mrrse_pkg::OP_CALL_EXIT, 8'h00, 8'h00, 3'h0);
        chk({pc_load_q, stack_pop_q, pc_value_q, flags_q}, {2'b11, 11'h5a3, 4'h5});
        stack_top <= 11'h2c1;
        do_op(mrrse_pkg::OP_CALL_EXIT_LIT, 8'h00, 8'hc3, 3'h0);
        chk({pc_value_q, acc_q, flags_q}, {11'h2c1, 8'hc3, 4'h5});
        do_op(mrrse_pkg::OP_INTERRUPT_EXIT, 8'h00, 8'h00, 3'h0);
        chk({pc_load_q, global_irq_gate_q}, 16'h0003);
        reg_read(mrrse_pkg::REG_CTRL, rd);
        chk(rd[0], 16'h0001);
        // op bit 0 copy, bit 1 carry, below 8 left
        for (int k = 0; k < 4; k++) begin
            for (int i = 4; i < 12; i++) begin
                m = k[0] ? 8'h69 : 8'h96;
                c = k[1];
                f = {3'b101, c};
                reg_write(mrrse_pkg::REG_FLAGS, {4'h0, f});
                reg_write(mrrse_pkg::REG_ACC, 8'h3c);
                if (i < 8) begin
                    r = {m[6:0], i[1] ? c : m[7]};
                    co = m[7];
                end else begin
                    r = {i[1] ? c : m[0], m[7:1]};
                    co = m[0];
                end
                do_op(i[4:0], m, 8'h00, 3'h0);
                chk({mem_we_q, i[0] ? acc_q : mem_wdata_q}, {!i[0], r});
                chk(flags_q, i[1] ? {f[3:1], co} : f);
            end
        end
        for (int i = 0; i < 5; i++) begin
            a = 8'h50 - 8'(i * 8'h28);
            m = 8'h17 + 8'(i * 8'h11);
            r = a - m;
            reg_write(mrrse_pkg::REG_ACC, a);
            do_op(mrrse_pkg::OP_SUBTRACT_TO_MEMORY, m, 8'h00, 3'h0);
            chk({mem_we_q, mem_wdata_q}, {1'b1, r});
            chk(flags_q, {(a[7] ^ m[7]) & (a[7] ^ r[7]), r == 8'h00, a[3:0] >= m[3:0], a >= m});
        end
        reg_write(mrrse_pkg::REG_FLAGS, 8'h0a);
        do_op(mrrse_pkg::OP_SET_BYTE, 8'h12, 8'h00, 3'h0);
        chk({mem_we_q, mem_wdata_q, flags_q}, {1'b1, 8'hff, 4'ha});
        for (int b = 0; b < 8; b++) begin
            do_op(mrrse_pkg::OP_SET_BIT, 8'h42, 8'h00, b[2:0]);
            chk({mem_we_q, mem_wdata_q, flags_q}, {1'b1, 8'h42 | (8'h01 << b), 4'ha});
        end
        for (int i = 15; i < 19; i++) begin
            for (int k = 0; k < 4; k++) begin
                m = 8'(32'hff00017f >> (24 - 8 * k));
                r = (i < 17) ? m + 8'h01 : m - 8'h01;
                reg_write(mrrse_pkg::REG_ACC, 8'h5c);
                do_op(i[4:0], m, 8'h00, 3'h0);
                chk({skip_dummy_q, mem_we_q, i[0] ? mem_wdata_q : acc_q}, {r == 8'h00, i[0], r});
                chk(flags_q, 16'h000a);
                @(posedge clk_sys);
                #1;
                chk(skip_dummy_q, 16'h0000);
            end
        end
        for (int b = 0; b < 8; b++) begin
            do_op(mrrse_pkg::OP_SKIP_BIT_NONZERO, 8'ha5, 8'h00, b[2:0]);
            chk({skip_dummy_q, mem_we_q, flags_q}, {8'ha5 >> b & 8'h01, 1'b0, 4'ha});
        end
        // op held into the dummy cycle is dropped
        @(posedge clk_sys);
        exec_valid <= 1'b1;
        exec_op <= mrrse_pkg::OP_INCREMENT_SKIP_ZERO;
        mem_rdata <= 8'hff;
        @(posedge clk_sys);
        exec_op <= mrrse_pkg::OP_SET_BYTE;
        @(posedge clk_sys);
        exec_valid <= 1'b0;
        #1;
        chk({skip_dummy_q, mem_we_q, mem_wdata_q}, 16'h0000);
        report_and_stop();
    end
endmodule // mrrse_rotate_return_skip_exec_test
`default_nettype wire
